// [rtl/cmxo_ctrl.sv]
/*
 * Clock multiplier and external oscillator control: registers, bring-up
 * sequencer, ratio/band decode and a clock-enable based multiplier model.
 * Assumes a single 10 MHz clock; oscillator edges arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
`include "cmxo_regs.svh"
module cmxo_ctrl
    import cmxo_pkg::*;
#(
    parameter int XTAL_SETTLE_CYC = `CMXO_XTAL_SETTLE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire cmxo_bus_t bus,
    output logic [7:0] rdata,
    // oscillator edges as one-cycle pulses, and the external running level
    input wire logic int_osc_edge,
    input wire logic ext_osc_edge,
    input wire logic ext_osc_running,
    // multiplier, oscillator config and interrupt outputs
    output logic mult_clk_en,
    output logic mult_ready,
    output cmxo_osc_cfg_t osc_cfg,
    output logic irq
);
    localparam int LOCK_CYC_RAW = (`CMXO_LOCK_TIME_NS * (`CMXO_CLK_HZ / 1000000) + 999) / 1000;
    localparam int LOCK_CYC = LOCK_CYC_RAW < 1 ? 1 : LOCK_CYC_RAW;

    logic [7:0] mult_control_reg;
    logic [2:0] ext_osc_mode_field;
    logic [2:0] ext_osc_freq_field;
    logic crystal_valid_flag;
    logic [`CMXO_IRQ_W-1:0] irq_stat_reg;
    logic [`CMXO_IRQ_W-1:0] irq_mask_reg;
    cmxo_state_t state_reg;
    logic [7:0] lock_cnt_reg;
    logic [15:0] settle_cnt_reg;
    logic half_tog_int_reg;
    logic half_tog_ext_reg;
    logic [2:0] pulses_left_reg;
    logic [7:0] gap_cnt_reg;
    logic [7:0] gap_len_reg;
    logic [7:0] period_cnt_reg;
    logic [7:0] ratio_acc_reg;
    logic mult_ready_flag;
    logic in_edge;
    logic [2:0] scale_den;
    logic xtal_mode;
    logic ready_event;
    logic xtal_event;

    // denominator of the 2/N scale; codes 0, 1 and 7 give 2/2, code 6 reaches 2/7
    function automatic logic [2:0] scale_denom(input logic [2:0] code);
        return (code == 3'h0 || code > 3'h6) ? 3'h2 : code + 3'h1;
    endfunction

    wire mult_wr = bus.wr && bus.addr == `CMXO_ADDR_MULT_CTRL;
    wire osc_wr = bus.wr && bus.addr == `CMXO_ADDR_EXT_OSC;
    wire mult_en = mult_control_reg[`CMXO_MULT_EN_BIT];
    wire mult_init = mult_control_reg[`CMXO_MULT_INIT_BIT];
    wire [1:0] mult_input_select = mult_control_reg[`CMXO_MULT_SEL_LSB +: 2];
    wire [2:0] mult_scale_select = mult_control_reg[`CMXO_MULT_SCALE_LSB +: 3];

    assign scale_den = scale_denom(mult_scale_select);
    assign xtal_mode = ext_osc_mode_field[2:1] == 2'b11;

    // input source choice
    always_comb begin
        unique case (cmxo_sel_t'(mult_input_select))
            CMXO_SEL_EXT: in_edge = ext_osc_edge;
            CMXO_SEL_INT_HALF: in_edge = int_osc_edge && half_tog_int_reg;
            CMXO_SEL_EXT_HALF: in_edge = ext_osc_edge && half_tog_ext_reg;
            CMXO_SEL_RSVD: in_edge = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            half_tog_int_reg <= 1'b0;
            half_tog_ext_reg <= 1'b0;
        end else begin
            if (int_osc_edge) half_tog_int_reg <= !half_tog_int_reg;
            if (ext_osc_edge) half_tog_ext_reg <= !half_tog_ext_reg;
        end
    end

    // control register; writing zero resets the multiplier
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) mult_control_reg <= `CMXO_RESET_VAL;
        else if (mult_wr) mult_control_reg <= {bus.wdata[7:6], 1'b0, bus.wdata[4:0]};
    end

    // oscillator register; bit 3 dropped modes and bands stored
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_osc_mode_field <= 3'h0;
            ext_osc_freq_field <= 3'h0;
        end else if (osc_wr) begin
            ext_osc_mode_field <= bus.wdata[`CMXO_XOSC_MODE_LSB +: 3];
            ext_osc_freq_field <= bus.wdata[`CMXO_XOSC_FREQ_LSB +: 3];
        end
    end

    // crystal valid only after settle time in modes 11x
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt_reg <= 16'h0000;
            crystal_valid_flag <= 1'b0;
        end else if (!xtal_mode || !ext_osc_running || osc_wr) begin
            settle_cnt_reg <= 16'h0000;
            crystal_valid_flag <= 1'b0;
        end else if (settle_cnt_reg < 16'(XTAL_SETTLE_CYC)) begin
            settle_cnt_reg <= settle_cnt_reg + 16'h0001;
        end else begin
            crystal_valid_flag <= 1'b1;
        end
    end

    // bring-up sequencer; lock count restarts at init, so every init waits the full lock time
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= CMXO_ST_RESET;
            lock_cnt_reg <= 8'h00;
        end else if (!mult_en) begin
            state_reg <= CMXO_ST_RESET;
            lock_cnt_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                CMXO_ST_RESET: begin
                    state_reg <= CMXO_ST_ENABLED;
                    lock_cnt_reg <= 8'h00;
                end
                CMXO_ST_ENABLED: begin
                    if (lock_cnt_reg < 8'(LOCK_CYC)) lock_cnt_reg <= lock_cnt_reg + 8'h01;
                    if (mult_init) begin
                        state_reg <= CMXO_ST_LOCKING;
                        lock_cnt_reg <= 8'h00;
                    end
                end
                CMXO_ST_LOCKING: begin
                    lock_cnt_reg <= lock_cnt_reg + 8'h01;
                    if (lock_cnt_reg >= 8'(LOCK_CYC - 1) && period_cnt_reg != 8'h00)
                        state_reg <= CMXO_ST_READY;
                end
                CMXO_ST_READY: begin
                    if (!mult_init) state_reg <= CMXO_ST_ENABLED;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) mult_ready_flag <= 1'b0;
        else mult_ready_flag <= mult_en && state_reg == CMXO_ST_READY;
    end

    // measure input period, derive pulse spacing for 4x scaled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            period_cnt_reg <= 8'h00;
            gap_len_reg <= 8'h00;
            ratio_acc_reg <= 8'h00;
        end else if (!mult_en) begin
            period_cnt_reg <= 8'h00;
            gap_len_reg <= 8'h00;
            ratio_acc_reg <= 8'h00;
        end else if (in_edge) begin
            period_cnt_reg <= 8'h01;
            gap_len_reg <= 8'((16'(ratio_acc_reg) * 16'(scale_den)) >> 3);
            ratio_acc_reg <= 8'h00;
        end else begin
            if (period_cnt_reg != 8'hff) period_cnt_reg <= period_cnt_reg + 8'h01;
            if (ratio_acc_reg != 8'hff) ratio_acc_reg <= ratio_acc_reg + 8'h01;
        end
    end

    // four pulses per input edge, then hold for the next edge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pulses_left_reg <= 3'h0;
            gap_cnt_reg <= 8'h00;
            mult_clk_en <= 1'b0;
        end else if (!mult_ready_flag) begin
            pulses_left_reg <= 3'h0;
            gap_cnt_reg <= 8'h00;
            mult_clk_en <= 1'b0;
        end else if (in_edge) begin
            pulses_left_reg <= 3'h3;
            gap_cnt_reg <= gap_len_reg;
            mult_clk_en <= 1'b1;
        end else if (pulses_left_reg != 3'h0 && gap_cnt_reg == 8'h00) begin
            pulses_left_reg <= pulses_left_reg - 3'h1;
            gap_cnt_reg <= gap_len_reg;
            mult_clk_en <= 1'b1;
        end else begin
            if (gap_cnt_reg != 8'h00) gap_cnt_reg <= gap_cnt_reg - 8'h01;
            mult_clk_en <= 1'b0;
        end
    end

    // sticky events, write one to clear, set beats clear
    assign ready_event = (state_reg == CMXO_ST_READY) && !mult_ready_flag && mult_en;
    // same terms as the flag set, so a restart write cannot raise a false event
    assign xtal_event = xtal_mode && ext_osc_running && !osc_wr && settle_cnt_reg >= 16'(XTAL_SETTLE_CYC)
        && !crystal_valid_flag;
    wire stat_wr = bus.wr && bus.addr == `CMXO_ADDR_IRQ_STAT;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) irq_stat_reg <= '0;
        else begin
            irq_stat_reg <= (irq_stat_reg & ~(stat_wr ? bus.wdata[`CMXO_IRQ_W-1:0] : '0))
                | {xtal_event, ready_event};
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) irq_mask_reg <= '0;
        else if (bus.wr && bus.addr == `CMXO_ADDR_IRQ_MASK) irq_mask_reg <= bus.wdata[`CMXO_IRQ_W-1:0];
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) irq <= 1'b0;
        else irq <= |(irq_stat_reg & irq_mask_reg);
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) rdata <= 8'h00;
        else if (bus.rd) begin
            unique case (bus.addr)
                `CMXO_ADDR_MULT_CTRL: rdata <= {mult_control_reg[7:6], mult_ready_flag, mult_control_reg[4:0]};
                `CMXO_ADDR_EXT_OSC: rdata <= {crystal_valid_flag, ext_osc_mode_field, 1'b0, ext_osc_freq_field};
                `CMXO_ADDR_IRQ_STAT: rdata <= {6'h00, irq_stat_reg};
                `CMXO_ADDR_IRQ_MASK: rdata <= {6'h00, irq_mask_reg};
                default: rdata <= 8'h00;
            endcase
        end else rdata <= 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mult_ready <= 1'b0;
            osc_cfg <= '0;
        end else begin
            mult_ready <= mult_ready_flag;
            osc_cfg <= '{mode: ext_osc_mode_field, freq: ext_osc_freq_field,
                         half: ext_osc_mode_field == 3'b111, xtal: xtal_mode};
        end
    end

    property p_ready_clears;
        @(posedge mclk) disable iff (!rst_b) !mult_en |=> !mult_ready_flag;
    endproperty
    a_ready_clears: assert property (p_ready_clears) else $error("ready flag not cleared");
    property p_ready_needs_init;
        @(posedge mclk) disable iff (!rst_b) $rose(mult_ready_flag) |-> $past(mult_init, 2);
    endproperty
    a_ready_needs_init: assert property (p_ready_needs_init) else $error("ready without init");
    property p_xtal_mode_only;
        @(posedge mclk) disable iff (!rst_b) crystal_valid_flag |-> $past(xtal_mode);
    endproperty
    a_xtal_mode_only: assert property (p_xtal_mode_only) else $error("crystal valid outside 11x");
    property p_bit3_zero;
        @(posedge mclk) disable iff (!rst_b) $past(bus.rd && bus.addr == `CMXO_ADDR_EXT_OSC) |-> !rdata[3];
    endproperty
    a_bit3_zero: assert property (p_bit3_zero) else $error("unused bit read as one");
    property p_four_pulses;
        @(posedge mclk) disable iff (!rst_b) pulses_left_reg == 3'h0 && !in_edge |=> !mult_clk_en;
    endproperty
    a_four_pulses: assert property (p_four_pulses) else $error("pulse beyond four per edge");
    property p_reset_write;
        @(posedge mclk) disable iff (!rst_b) mult_wr && bus.wdata == 8'h00 |=> ##1 state_reg == CMXO_ST_RESET;
    endproperty
    a_reset_write: assert property (p_reset_write) else $error("zero write did not reset multiplier");
    property p_mode_out;
        @(posedge mclk) disable iff (!rst_b) osc_wr |=> ##1 osc_cfg.mode == $past(bus.wdata[6:4], 2);
    endproperty
    a_mode_out: assert property (p_mode_out) else $error("mode field not decoded");
    property p_irq;
        @(posedge mclk) disable iff (!rst_b) $rose(mult_ready_flag) |-> irq_stat_reg[`CMXO_IRQ_READY];
    endproperty
    a_irq: assert property (p_irq) else $error("ready event not latched");
    property p_clk_en_gated;
        @(posedge mclk) disable iff (!rst_b) mult_clk_en |-> $past(mult_ready_flag);
    endproperty
    a_clk_en_gated: assert property (p_clk_en_gated) else $error("output pulse while not ready");
    c_ready: cover property (@(posedge mclk) $rose(mult_ready_flag));
    c_pulse: cover property (@(posedge mclk) in_edge ##1 mult_clk_en);
    c_xtal: cover property (@(posedge mclk) $rose(crystal_valid_flag));
endmodule

// [common/cmxo_regs.svh]
/*
 * Register map, field positions, reset values and timing counts of the
 * clock multiplier and external oscillator control block.
 * Assumes an 8-bit register port with one-cycle strobes.
 */
`ifndef CMXO_REGS_SVH
`define CMXO_REGS_SVH

`define CMXO_ADDR_MULT_CTRL 8'hbe
`define CMXO_ADDR_EXT_OSC 8'h9f
`define CMXO_ADDR_IRQ_STAT 8'hbc
`define CMXO_ADDR_IRQ_MASK 8'hbd

`define CMXO_MULT_EN_BIT 7
`define CMXO_MULT_INIT_BIT 6
`define CMXO_MULT_RDY_BIT 5
`define CMXO_MULT_SCALE_LSB 2
`define CMXO_MULT_SEL_LSB 0

`define CMXO_XOSC_VLD_BIT 7
`define CMXO_XOSC_MODE_LSB 4
`define CMXO_XOSC_FREQ_LSB 0

`define CMXO_RESET_VAL 8'h00
`define CMXO_CLK_HZ 10000000
`define CMXO_LOCK_TIME_NS 5000
`define CMXO_XTAL_SETTLE_CYC 1024

`define CMXO_IRQ_READY 0
`define CMXO_IRQ_XTAL 1
`define CMXO_IRQ_W 2

`endif

// [common/cmxo_pkg.sv]
/*
 * Types of the clock multiplier and external oscillator control block.
 * Assumes cmxo_regs.svh for all numeric values.
 */
package cmxo_pkg;
    typedef enum logic [1:0] {
        CMXO_SEL_EXT = 2'b00,
        CMXO_SEL_INT_HALF = 2'b01,
        CMXO_SEL_EXT_HALF = 2'b10,
        CMXO_SEL_RSVD = 2'b11
    } cmxo_sel_t;

    typedef enum logic [2:0] {
        CMXO_OSC_OFF = 3'b000,
        CMXO_OSC_CMOS = 3'b010,
        CMXO_OSC_CMOS_HALF = 3'b011,
        CMXO_OSC_RC = 3'b100,
        CMXO_OSC_CAP = 3'b101,
        CMXO_OSC_XTAL = 3'b110,
        CMXO_OSC_XTAL_HALF = 3'b111
    } cmxo_osc_mode_t;

    typedef enum logic [1:0] {
        CMXO_ST_RESET = 2'b00,
        CMXO_ST_ENABLED = 2'b01,
        CMXO_ST_LOCKING = 2'b10,
        CMXO_ST_READY = 2'b11
    } cmxo_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cmxo_bus_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] freq;
        logic half;
        logic xtal;
    } cmxo_osc_cfg_t;
endpackage

// [verification/tb_cmxo_ctrl.sv]
/*
 * Self-checking bench of the clock multiplier and external oscillator control.
 * Assumes cmxo_pkg, cmxo_regs.svh and the control module are compiled first.
 */
`timescale 1ns/1ps
`include "cmxo_regs.svh"
module tb_cmxo_ctrl
    import cmxo_pkg::*;
;
    localparam int SETTLE = 4;
    logic mclk;
    logic rst_b;
    cmxo_bus_t bus;
    logic [7:0] rdata;
    logic int_osc_edge;
    logic ext_osc_edge;
    logic ext_osc_running;
    logic mult_clk_en;
    logic mult_ready;
    cmxo_osc_cfg_t osc_cfg;
    logic irq;
    int miscompares = 0;
    int total_checks = 0;
    int clk_en_count = 0;
    logic [31:0] rng_state = 32'h0000_8495;

    cmxo_ctrl #(.XTAL_SETTLE_CYC(SETTLE)) dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .int_osc_edge(int_osc_edge), .ext_osc_edge(ext_osc_edge), .ext_osc_running(ext_osc_running),
        .mult_clk_en(mult_clk_en), .mult_ready(mult_ready), .osc_cfg(osc_cfg), .irq(irq));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (mult_clk_en === 1'b1) clk_en_count <= clk_en_count + 1;
    end

    function automatic logic [31:0] xorshift();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 17);
        rng_state = rng_state ^ (rng_state << 5);
        return rng_state;
    endfunction

    task automatic stop_test();
        if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1;
        data = rdata;
    endtask

    task automatic expect_reg(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        reg_read(addr, v);
        check_val(what, exp, v);
    endtask

    task automatic osc_edges(input bit use_int, input int n, input int gap);
        repeat (n) begin
            @(posedge mclk);
            if (use_int) int_osc_edge <= 1'b1;
            else ext_osc_edge <= 1'b1;
            @(posedge mclk);
            int_osc_edge <= 1'b0;
            ext_osc_edge <= 1'b0;
            repeat (gap - 2) @(posedge mclk);
        end
    endtask

    // full bring-up, then output pulses counted over eight input edges
    task automatic bring_up(input logic [1:0] sel);
        logic [7:0] v;
        int i;
        int start;
        reg_write(`CMXO_ADDR_MULT_CTRL, 8'h00);
        reg_write(`CMXO_ADDR_MULT_CTRL, {6'h00, sel});
        reg_write(`CMXO_ADDR_MULT_CTRL, {6'h00, sel});
        reg_write(`CMXO_ADDR_MULT_CTRL, {6'h20, sel});
        osc_edges(sel == 2'b01, 2, 30);
        check_bit("ready before init", 1'b0, mult_ready);
        expect_reg("control enabled", `CMXO_ADDR_MULT_CTRL, {6'h20, sel});
        reg_write(`CMXO_ADDR_MULT_CTRL, {6'h30, sel});
        osc_edges(sel == 2'b01, 2, 64);
        i = 0;
        do begin
            reg_read(`CMXO_ADDR_MULT_CTRL, v);
            i++;
        end while (v[5] !== 1'b1 && i < 100);
        if (v[5] !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        check_val("control ready", {6'h38, sel}, v);
        check_bit("ready port", 1'b1, mult_ready);
        start = clk_en_count;
        osc_edges(sel == 2'b01, 8, 64);
        repeat (200) @(posedge mclk);
        check_count("output pulses", (sel == 2'b00) ? 32 : 16, clk_en_count - start);
        expect_reg("ready status", `CMXO_ADDR_IRQ_STAT, 8'h01);
        reg_write(`CMXO_ADDR_IRQ_MASK, 8'h01);
        @(posedge mclk);
        #1;
        check_bit("irq unmasked", 1'b1, irq);
        reg_write(`CMXO_ADDR_IRQ_STAT, 8'h01);
        @(posedge mclk);
        #1;
        check_bit("irq cleared", 1'b0, irq);
        reg_write(`CMXO_ADDR_IRQ_MASK, 8'h00);
        reg_write(`CMXO_ADDR_MULT_CTRL, 8'h00);
        // flag drops one edge after the write lands, the port copy one edge later
        repeat (2) @(posedge mclk);
        #1;
        check_bit("ready after reset write", 1'b0, mult_ready);
        expect_reg("control reset", `CMXO_ADDR_MULT_CTRL, 8'h00);
    endtask

    initial begin
        logic [2:0] m;
        logic [2:0] f;
        logic [1:0] s;
        logic [7:0] stat_model;
        rst_b = 1'b0;
        bus = '0;
        int_osc_edge = 1'b0;
        ext_osc_edge = 1'b0;
        ext_osc_running = 1'b0;
        stat_model = 8'h00;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        expect_reg("osc reset", `CMXO_ADDR_EXT_OSC, 8'h00);
        expect_reg("control reset", `CMXO_ADDR_MULT_CTRL, 8'h00);
        expect_reg("status reset", `CMXO_ADDR_IRQ_STAT, 8'h00);
        expect_reg("mask reset", `CMXO_ADDR_IRQ_MASK, 8'h00);
        reg_write(8'h12, 8'(xorshift()));
        expect_reg("unmapped", 8'h12, 8'h00);
        // scale and input codes, enable left off
        for (int c = 0; c < 8; c++) begin
            s = 2'(xorshift() % 3);
            reg_write(`CMXO_ADDR_MULT_CTRL, {3'b000, 3'(c), s});
            expect_reg("control fields", `CMXO_ADDR_MULT_CTRL, {3'b000, 3'(c), s});
        end
        ext_osc_running <= 1'b1;
        // every mode; unused bit 3 written as zero
        for (int k = 0; k < 9; k++) begin
            m = (k == 8) ? 3'b110 : 3'(k);
            f = 3'(xorshift());
            reg_write(`CMXO_ADDR_EXT_OSC, {1'b0, m, 1'b0, f});
            expect_reg("osc restart", `CMXO_ADDR_EXT_OSC, {1'b0, m, 1'b0, f});
            repeat (SETTLE + 10) @(posedge mclk);
            expect_reg("osc settled", `CMXO_ADDR_EXT_OSC, {m[2:1] == 2'b11, m, 1'b0, f});
            check_val("osc mode", {5'h00, m}, {5'h00, osc_cfg.mode});
            check_val("osc freq", {5'h00, f}, {5'h00, osc_cfg.freq});
            check_bit("osc crystal", m[2:1] == 2'b11, osc_cfg.xtal);
            check_bit("osc half", m == 3'b111, osc_cfg.half);
            if (m[2:1] == 2'b11) stat_model = stat_model | 8'h02;
        end
        expect_reg("crystal status", `CMXO_ADDR_IRQ_STAT, stat_model);
        check_bit("irq masked", 1'b0, irq);
        reg_write(`CMXO_ADDR_IRQ_MASK, 8'h02);
        @(posedge mclk);
        #1;
        check_bit("irq crystal", 1'b1, irq);
        reg_write(`CMXO_ADDR_IRQ_STAT, 8'h02);
        reg_write(`CMXO_ADDR_IRQ_MASK, 8'h00);
        expect_reg("status cleared", `CMXO_ADDR_IRQ_STAT, 8'h00);
        check_bit("irq idle", 1'b0, irq);
        // crystal stable before the multiplier is fed from it
        for (int k = 0; k < 3; k++) bring_up(2'(k));
        stop_test();
    end
endmodule
